// ### phase_table.sv
/*
 * quarter-wave sine table folded into signed currents for both phases.
 * assumes the index is stable; purely combinational lookup.
 */
`timescale 1ns/1ps
module phase_table
    import step_translator_pkg::*;
(
    input  wire logic [INDEX_W-1:0] index_i,        // step angle index
    output logic      [CODE_W-1:0]  mag_a_o,        // phase a magnitude code
    output logic                    neg_a_o,        // phase a negative
    output logic      [CODE_W-1:0]  mag_b_o,        // phase b magnitude code
    output logic                    neg_b_o         // phase b negative
);
    // sine of k*5.625 deg for k = 0..16 scaled to 6 bits, saturating at full code
    function automatic logic [5:0] sine_q(input logic [4:0] k);
        case (k)
            5'h00: sine_q = 6'h00;
            5'h01: sine_q = 6'h06;
            5'h02: sine_q = 6'h0C;
            5'h03: sine_q = 6'h12;
            5'h04: sine_q = 6'h18;
            5'h05: sine_q = 6'h1D;
            5'h06: sine_q = 6'h23;
            5'h07: sine_q = 6'h28;
            5'h08: sine_q = 6'h2D;
            5'h09: sine_q = 6'h31;
            5'h0A: sine_q = 6'h35;
            5'h0B: sine_q = 6'h38;
            5'h0C: sine_q = 6'h3B;
            5'h0D: sine_q = 6'h3D;
            5'h0E: sine_q = 6'h3E;
            5'h0F: sine_q = 6'h3F;
            default: sine_q = CODE_FULL;
        endcase
    endfunction

    wire logic [1:0] quad = index_i[5:4];              // quadrant of the cycle
    wire logic [3:0] pos  = index_i[3:0];              // position inside quadrant
    wire logic [4:0] up   = {1'b0, pos};               // rising part of the sine
    wire logic [4:0] down = 5'h10 - {1'b0, pos};       // falling part

    // phase a rises from zero at index 0 (sine), phase b starts at full (cosine)
    assign mag_a_o = (quad[0]) ? sine_q(down) : sine_q(up);
    assign mag_b_o = (quad[0]) ? sine_q(up)   : sine_q(down);
    assign neg_a_o = quad[1] && (mag_a_o != 6'h00);
    assign neg_b_o = (quad == 2'h1 || quad == 2'h2) && (mag_b_o != 6'h00);
endmodule

// ### step_controller.sv
/*
 * behavioural model of the external controller driving the step, direction
 * and resolution select pins.
 * assumes one free-running clock; pins change only at its falling edge.
 */
`timescale 1ns/1ps
module step_controller (
    input  wire logic clock_i,        // system clock
    output logic      step_o,         // step pin
    output logic      direction_o,    // direction pin
    output logic      sel_low_o,      // select pin, low bit
    output logic      sel_high_o      // select pin, high bit
);
    // pins start low so the register copy alone decides the resolution
    initial begin
        step_o = 1'b0;
        direction_o = 1'b0;
        sel_low_o = 1'b0;
        sel_high_o = 1'b0;
    end

    // select pins only move between step pulses, never near an edge
    task automatic set_mode(input logic [1:0] m);
        @(negedge clock_i);
        {sel_high_o, sel_low_o} = m;
    endtask

    // one pulse; levels held three cycles so the synchroniser sees them
    // serial changes are never issued while a pulse is in flight
    task automatic pulse(input logic fwd);
        @(negedge clock_i);
        direction_o = fwd;
        repeat (3) @(negedge clock_i);
        step_o = 1'b1;
        repeat (3) @(negedge clock_i);
        step_o = 1'b0;
        repeat (3) @(negedge clock_i);
    endtask
endmodule

// ### step_direction_translator.sv
/*
 * step and direction translator: keeps the 64-position step angle index and
 * drives the two phase current codes from it.
 * assumes step, direction and select pins are asynchronous to clock_i; the
 * serial path delivers register select bits and signed index changes already
 * synchronised and as a one-cycle pulse.
 */
`timescale 1ns/1ps
module step_direction_translator
    import step_translator_pkg::*;
(
    input  wire logic                    clock_i,                     // 25 mhz system clock
    input  wire logic                    arst_n_i,                    // async reset, active low
    input  wire logic                    step_i,                      // step pin
    input  wire logic                    direction_i,                 // direction pin
    input  wire logic                    resolution_select_low_i,     // select pin, low bit
    input  wire logic                    resolution_select_high_i,    // select pin, high bit
    input  wire logic                    cfg_select_we_i,             // write register select copy
    input  wire logic [1:0]              cfg_select_i,                // register select value
    input  wire logic                    serial_change_i,             // apply serial change pulse
    input  wire logic [INDEX_W-1:0]      serial_delta_i,              // two's complement change
    output logic      [INDEX_W-1:0]      step_index_o,                // current step angle index
    output logic      [1:0]              resolution_o,                // effective resolution
    output logic      [CODE_W-1:0]       current_a_o,                 // phase a code
    output logic                         current_a_neg_o,             // phase a sign
    output logic      [CODE_W-1:0]       current_b_o,                 // phase b code
    output logic                         current_b_neg_o              // phase b sign
);
    import step_translator_pkg::*;

    // two-stage synchronisers; the first stage feeds only the second
    logic [3:0] sync1_reg;                          // first stage: step, dir, sel low, sel high
    logic [3:0] sync2_reg;                          // second stage, safe to read
    logic       step_prev_reg;                      // previous synced step level
    logic [1:0] cfg_sel_reg;                        // register copy of the select bits
    logic [5:0] index_reg;                          // step angle index
    logic [5:0] index_next;                         // next index
    logic [5:0] mag_a, mag_b;                       // table outputs
    logic       neg_a, neg_b;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_reg     <= 4'h0;
            sync2_reg     <= 4'h0;
            step_prev_reg <= 1'b0;
        end else begin
            sync1_reg     <= {resolution_select_high_i, resolution_select_low_i,
                              direction_i, step_i};
            sync2_reg     <= sync1_reg;
            step_prev_reg <= sync2_reg[0];
        end
    end

    wire logic step_s   = sync2_reg[0];                      // synced step level
    wire logic dir_s    = sync2_reg[1];                      // synced direction
    wire logic step_rise = step_s && !step_prev_reg;         // one pulse per edge

    // register copy of the select bits; cleared by reset so pins rule alone
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_sel_reg <= SEL_RESET;
        end else if (cfg_select_we_i) begin
            cfg_sel_reg <= cfg_select_i;
        end
    end

    // effective resolution, pins ORed with the register copy
    wire logic [1:0] res_sel = sync2_reg[3:2] | cfg_sel_reg;
    res_mode_t mode;
    assign mode = res_mode_t'(res_sel);

    // step size per resolution
    function automatic logic [5:0] step_size(input res_mode_t m);
        case (m)
            MODE_FULL:    step_size = STEP_FULL;
            MODE_HALF:    step_size = STEP_HALF;
            MODE_QUARTER: step_size = STEP_QUARTER;
            MODE_SIXTEEN: step_size = STEP_SIXTEEN;
            default:      step_size = STEP_SIXTEEN;
        endcase
    endfunction

    // next allowed grid value in the chosen direction; the grid is spaced by
    // size and offset by off. rounding from off-grid values lands on the
    // nearest grid point beyond, so a resolution change settles in one edge.
    function automatic logic [5:0] next_on_grid(input logic [5:0] cur,
                                                input logic [5:0] size,
                                                input logic [5:0] off,
                                                input logic       fwd);
        logic [5:0] rel;
        logic [5:0] mask;
        logic [5:0] base;
        rel  = 6'h00;
        mask = 6'h00;
        base = 6'h00;
        rel  = cur - off;
        mask = ~(size - 6'h01);
        base = rel & mask;                                     // grid point at or below
        if (fwd) begin
            next_on_grid = base + size + off;
        end else if (base != rel) begin
            next_on_grid = base + off;                         // off grid: drop to it
        end else begin
            next_on_grid = base - size + off;
        end
    endfunction

    wire logic [5:0] size_sel = step_size(mode);
    wire logic [5:0] off_sel  = (mode == MODE_FULL) ? FULL_OFFSET : INDEX_RESET;
    wire logic [5:0] step_target =
        next_on_grid(index_reg, size_sel, off_sel, dir_s);

    // serial change ignores resolution; step edge wins if both coincide
    always_comb begin
        index_next = index_reg;
        if (step_rise) begin
            index_next = step_target;
        end else if (serial_change_i) begin
            index_next = index_reg + serial_delta_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            index_reg <= INDEX_RESET;
        end else begin
            index_reg <= index_next;
        end
    end

    phase_table u_table (
        .index_i (index_next),
        .mag_a_o (mag_a),
        .neg_a_o (neg_a),
        .mag_b_o (mag_b),
        .neg_b_o (neg_b)
    );

    // registered index and phase outputs track the index register one-for-one; resolution_o registers res_sel
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            step_index_o    <= INDEX_RESET;
            resolution_o    <= RES_FULL;
            current_a_o     <= 6'h00;                          // index 0: a is zero
            current_a_neg_o <= 1'b0;
            current_b_o     <= CODE_FULL;                      // index 0: b full positive
            current_b_neg_o <= 1'b0;
        end else begin
            step_index_o    <= index_next;
            resolution_o    <= res_sel;
            current_a_o     <= mag_a;
            current_a_neg_o <= neg_a;
            current_b_o     <= mag_b;
            current_b_neg_o <= neg_b;
        end
    end

    // assertions
    index_moves_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (step_rise && mode == MODE_SIXTEEN && dir_s) |=> index_reg == $past(index_reg) + 6'h01)
        else $error("sixteenth forward step did not add one");
    index_back_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (step_rise && mode == MODE_SIXTEEN && !dir_s) |=> index_reg == $past(index_reg) - 6'h01)
        else $error("sixteenth reverse step did not subtract one");
    full_grid_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (step_rise && mode == MODE_FULL) |=> index_reg[3:0] == 4'h8)
        else $error("full step left the 45 degree positions");
    half_grid_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (step_rise && mode == MODE_HALF) |=> index_reg[2:0] == 3'h0)
        else $error("half step left the multiples of eight");
    quarter_grid_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (step_rise && mode == MODE_QUARTER) |=> index_reg[1:0] == 2'h0)
        else $error("quarter step left the multiples of four");
    serial_move_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (serial_change_i && !step_rise) |=> index_reg == $past(index_reg) + $past(serial_delta_i))
        else $error("serial change not applied modulo 64");
    hold_still_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (!step_rise && !serial_change_i) |=> $stable(index_reg))
        else $error("index moved without a cause");
    step_once_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        step_rise |=> !step_rise)
        else $error("one step edge gave two updates");
    select_or_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        1'b1 |=> resolution_o == ($past(sync2_reg[3:2]) | $past(cfg_sel_reg)))
        else $error("resolution is not pin OR register");
    axis_point_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (step_index_o[3:0] == 4'h0) |-> ((current_a_o == 6'h00) != (current_b_o == 6'h00)))
        else $error("axis index does not put exactly one phase at zero");
endmodule

// ### step_direction_translator_tb_top.sv
/*
 * self-checking testbench for the step and direction translator.
 * assumes the controller model above drives the pins; the bench drives the
 * serial stand-in ports and the reset at the falling edge.
 */
`timescale 1ns/1ps
module step_direction_translator_tb_top;
    import step_translator_pkg::*;
    logic       clock_i, arst_n_i;            // clock and reset
    logic       step_w, dir_w, sel_lo_w, sel_hi_w; // controller pins
    logic       cfg_select_we_i;              // register copy write
    logic [1:0] cfg_select_i;                 // register copy value
    logic       serial_change_i;              // serial change pulse
    logic [5:0] serial_delta_i;               // serial change amount
    logic [5:0] step_index_o, current_a_o, current_b_o; // observed outputs
    logic [1:0] resolution_o;                 // effective resolution
    logic       current_a_neg_o, current_b_neg_o; // phase signs
    logic [5:0] exp_idx;                      // predicted index
    int         n_mismatch, tests_run, cycles; // bookkeeping

    // free-running 25 mhz clock
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    step_controller ctl (.clock_i(clock_i), .step_o(step_w), .direction_o(dir_w),
        .sel_low_o(sel_lo_w), .sel_high_o(sel_hi_w));

    step_direction_translator DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .step_i(step_w),
        .direction_i(dir_w), .resolution_select_low_i(sel_lo_w),
        .resolution_select_high_i(sel_hi_w), .cfg_select_we_i(cfg_select_we_i),
        .cfg_select_i(cfg_select_i), .serial_change_i(serial_change_i),
        .serial_delta_i(serial_delta_i), .step_index_o(step_index_o),
        .resolution_o(resolution_o), .current_a_o(current_a_o),
        .current_a_neg_o(current_a_neg_o), .current_b_o(current_b_o),
        .current_b_neg_o(current_b_neg_o));

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hang counts as a failure; the whole run needs well under 3000 cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk_val(input logic [5:0] got, input logic [5:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask

    // predicted grid move: next point above going forward, below going back
    function automatic logic [5:0] next_idx(input logic [5:0] idx, input logic [1:0] m,
                                            input logic fwd);
        int s, off, r, q;
        if (m == RES_SIXTEEN) return fwd ? idx + 6'h01 : idx - 6'h01;
        s = (m == RES_FULL) ? 16 : (m == RES_HALF) ? 8 : 4;
        off = (m == RES_FULL) ? 8 : 0;
        r = (int'(idx) - off + 64) % 64;
        q = r / s;
        if (fwd) q = q + 1;
        else if (r % s == 0) q = q - 1;
        return 6'((q * s + off + 64) % 64);
    endfunction

    task automatic serial_move(input logic [5:0] d);
        @(negedge clock_i);
        serial_change_i = 1'b1;
        serial_delta_i = d;
        @(negedge clock_i);
        serial_change_i = 1'b0;
        exp_idx = exp_idx + d;
        chk_val(step_index_o, exp_idx, "serial move");
    endtask

    task automatic step_move(input logic [1:0] m, input logic fwd);
        exp_idx = next_idx(exp_idx, m, fwd);
        ctl.pulse(fwd);
        chk_val(step_index_o, exp_idx, "step move");
    endtask

    task automatic cfg_write(input logic [1:0] v);
        @(negedge clock_i);
        cfg_select_we_i = 1'b1;
        cfg_select_i = v;
        @(negedge clock_i);
        cfg_select_we_i = 1'b0;
        @(negedge clock_i);
    endtask

    // one-per-edge moves in the finest mode, wrapping both ways
    task automatic t_fine;
        ctl.set_mode(RES_SIXTEEN);
        step_move(RES_SIXTEEN, 1'b0);
        step_move(RES_SIXTEEN, 1'b1);
        step_move(RES_SIXTEEN, 1'b1);
        chk_val({4'h0, resolution_o}, {4'h0, RES_SIXTEEN}, "resolution");
    endtask

    // from 59 change to each coarse mode, then walk the grid both ways
    task automatic t_coarse;
        logic [1:0] md;
        for (int m = 0; m < 3; m++) begin
            md = 2'(m);
            serial_move(6'h3B - exp_idx);
            ctl.set_mode(md);
            step_move(md, 1'b1);
            repeat (4) step_move(md, 1'b1);
            repeat (5) step_move(md, 1'b0);
            chk_val({4'h0, resolution_o}, {4'h0, md}, "resolution");
        end
    endtask

    // register copy ORed with the pins; serial moves ignore the mode
    task automatic t_or_reg;
        ctl.set_mode(RES_FULL);
        cfg_write(RES_SIXTEEN);
        chk_val({4'h0, resolution_o}, {4'h0, RES_SIXTEEN}, "register select");
        step_move(RES_SIXTEEN, 1'b1);
        cfg_write(RES_FULL);
        serial_move(6'h01);
        ctl.set_mode(RES_HALF);
        cfg_write(RES_QUARTER);
        chk_val({4'h0, resolution_o}, {4'h0, RES_SIXTEEN}, "pin or register");
        cfg_write(RES_FULL);
        chk_val({4'h0, resolution_o}, {4'h0, RES_HALF}, "pin only");
        step_move(RES_HALF, 1'b0);
    endtask

    // quarter points of the cycle: sine on phase a, cosine on phase b
    task automatic t_table;
        serial_move(6'h10 - exp_idx);
        chk_val(current_a_o, CODE_FULL, "phase a at 90");
        chk_val(current_b_o, 6'h00, "phase b at 90");
        serial_move(6'h10);
        chk_val(current_b_o, CODE_FULL, "phase b at 180");
        chk_bit(current_b_neg_o, 1'b1, "phase b sign");
        serial_move(6'h10);
        chk_bit(current_a_neg_o, 1'b1, "phase a sign");
        serial_move(6'h08 - exp_idx);
    endtask

    // main sequence: reset values first, then each scenario
    initial begin
        arst_n_i = 1'b0;
        cfg_select_we_i = 1'b0;
        cfg_select_i = 2'h0;
        serial_change_i = 1'b0;
        serial_delta_i = 6'h00;
        exp_idx = INDEX_RESET;
        repeat (3) @(negedge clock_i);
        chk_val(step_index_o, 6'h00, "reset index");
        chk_val({4'h0, resolution_o}, 6'h00, "reset resolution");
        chk_val(current_a_o, 6'h00, "reset phase a");
        chk_val(current_b_o, CODE_FULL, "reset phase b");
        chk_bit(current_b_neg_o, 1'b0, "reset phase b sign");
        chk_bit(current_a_neg_o, 1'b0, "reset phase a sign");
        arst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        t_fine();
        t_coarse();
        t_or_reg();
        t_table();
        tally_and_finish();
    end
endmodule

// ### step_translator_pkg.sv
/*
 * constants shared by the step and direction translator and its phase table.
 * assumes a single 25 mhz clock domain; step, direction and resolution pins
 * arrive asynchronously from an external controller.
 */
// Overview of operation
// - six-bit index selects one of 64 entries
// - sixteen index positions per full step
// - entry gives magnitude and sign per phase
// - each phase current is a 6-bit code
// - select bits decode full, half, quarter, sixteenth
// - effective select is pin OR register bit
// - register select copies reset to zero
// - resolution only affects step-input movement
// - sixteenth mode moves index by one
// - full step uses only 8,24,40,56
// - half step uses multiples of eight
// - quarter step uses multiples of four
// - resolution change goes to next allowed value
// - index step is 5.625 degrees, zero at phase B
// - index arithmetic wraps modulo 64
package step_translator_pkg;
    localparam int INDEX_W        = 6;                  // index width
    localparam int CODE_W         = 6;                  // converter code width
    localparam logic [5:0] INDEX_RESET = 6'h00;         // index after reset
    localparam logic [5:0] FULL_OFFSET = 6'h08;         // full step sits mid-quadrant
    localparam logic [5:0] CODE_FULL   = 6'h3F;         // largest magnitude code
    localparam logic [1:0] SEL_RESET   = 2'h0;          // register copy reset value
    // step sizes in index units per resolution
    localparam logic [5:0] STEP_FULL    = 6'h10;
    localparam logic [5:0] STEP_HALF    = 6'h08;
    localparam logic [5:0] STEP_QUARTER = 6'h04;
    localparam logic [5:0] STEP_SIXTEEN = 6'h01;
    localparam logic [3:0] QUAD_MAX     = 4'hF;         // last position in a quadrant
    // resolution encodings, high bit then low bit
    localparam logic [1:0] RES_FULL     = 2'h0;
    localparam logic [1:0] RES_HALF     = 2'h1;
    localparam logic [1:0] RES_QUARTER  = 2'h2;
    localparam logic [1:0] RES_SIXTEEN  = 2'h3;
    typedef enum logic [1:0] {MODE_FULL, MODE_HALF, MODE_QUARTER, MODE_SIXTEEN} res_mode_t;
endpackage
